// *** src/pixel_link_pkg.sv ***
package pixel_link_pkg;
    // parallel word and lane layout
    localparam int unsigned WORD_W = 21;
    localparam int unsigned COLOR_W = 6;
    localparam int unsigned LANE_N = 3;
    localparam int unsigned SLOT_N = 7;
    // control bit positions inside the parallel word
    localparam int unsigned LINE_SYNC_POS = 18;
    localparam int unsigned FRAME_SYNC_POS = 19;
    localparam int unsigned DATA_VALID_POS = 20;
    // forwarded clock pattern, slot 0 first: four high, three low
    localparam logic [6:0] FWD_CLK_PATTERN = 7'h0F;
    // serial slot clock: one slot per this many core cycles
    localparam int unsigned SLOT_DIV = 1;
    // reset values
    localparam logic [20:0] WORD_RESET = 21'h000000;
    localparam logic [2:0] LANE_RESET = 3'h0;
endpackage

// *** src/pixel_lvds_serializer_tx.sv ***
// Function
// - capture all 21 parallel bits together
// - default capture on falling shift edge
// - edge select high means rising capture
// - power down low tristates all lane and forwarded clock outputs
// - seven slots per lane per shift period
// - three serial data lanes carry word
// - forwarded clock at shift clock rate
`timescale 1ns/1ps
module pixel_lvds_serializer_tx #(
    parameter int unsigned DEPTH = 2
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // parallel side from the graphics controller
    input wire logic shift_clock_in,
    input wire logic [20:0] parallel_pixel_in,
    input wire logic strobe_edge_select,
    input wire logic power_down_n,
    // serial side
    output logic [2:0] serial_lane_out,
    output logic [2:0] serial_lane_oe,
    output logic forwarded_clock_out,
    output logic forwarded_clock_oe,
    // buffer state for observation
    output logic overrun
);
    // elaboration check: the buffer logic serves two entries only
    if (DEPTH != 2)
    begin : g_bad_depth
        $error("buffer depth must be 2");
    end

    // two-flop synchronisers for the pins, third flop for edge detect
    logic clk_s1_q, clk_s2_q, clk_s3_q;
    logic [20:0] pix_s1_q, pix_s2_q;
    logic sel_s1_q, sel_s2_q, pd_s1_q, pd_s2_q;

    // synchronise every pin input
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            clk_s1_q <= 1'b0;
            clk_s2_q <= 1'b0;
            clk_s3_q <= 1'b0;
            pix_s1_q <= pixel_link_pkg::WORD_RESET;
            pix_s2_q <= pixel_link_pkg::WORD_RESET;
            sel_s1_q <= 1'b0;
            sel_s2_q <= 1'b0;
            pd_s1_q <= 1'b0;
            pd_s2_q <= 1'b0;
        end
        else
        begin
            clk_s1_q <= shift_clock_in;
            clk_s2_q <= clk_s1_q;
            clk_s3_q <= clk_s2_q;
            pix_s1_q <= parallel_pixel_in;
            pix_s2_q <= pix_s1_q;
            sel_s1_q <= strobe_edge_select;
            sel_s2_q <= sel_s1_q;
            pd_s1_q <= power_down_n;
            pd_s2_q <= pd_s1_q;
        end
    end

    // edge detection on the synchronised shift clock
    logic rise, fall, strobe, active;
    assign rise = clk_s2_q & ~clk_s3_q;
    assign fall = ~clk_s2_q & clk_s3_q;
    assign active = pd_s2_q;
    assign strobe = active & (sel_s2_q ? rise : fall);

    // two-entry buffer
    logic [20:0] buf_q [0:1];
    logic [20:0] buf_d [0:1];
    logic [1:0] cnt_q, cnt_d;
    logic in_valid, in_ready, out_valid, out_ready, ovr_q, ovr_d;
    assign in_valid = strobe;
    assign in_ready = cnt_q != 2'h2;
    assign out_valid = cnt_q != 2'h0;

    // slot machine
    typedef enum logic [0:0] {ST_IDLE, ST_SEND} state_t;
    state_t st_q, st_d;
    logic [2:0] slot_q, slot_d;
    logic [20:0] word_q, word_d;
    assign out_ready = (st_q == ST_IDLE) |
        (slot_q == 3'(pixel_link_pkg::SLOT_N - 1));

    // buffer next state; whole word moves as one
    always_comb
    begin
        buf_d[0] = buf_q[0];
        buf_d[1] = buf_q[1];
        cnt_d = cnt_q;
        ovr_d = ovr_q | (in_valid & ~in_ready);
        if (out_valid & out_ready)
        begin
            buf_d[0] = buf_q[1];
            cnt_d = cnt_d - 2'h1;
        end
        if (in_valid & in_ready)
        begin
            buf_d[cnt_d[0]] = pix_s2_q;
            cnt_d = cnt_d + 2'h1;
        end
        if (!active)
        begin
            cnt_d = 2'h0;
            ovr_d = 1'b0;
        end
    end

    // buffer registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            buf_q[0] <= pixel_link_pkg::WORD_RESET;
            buf_q[1] <= pixel_link_pkg::WORD_RESET;
            cnt_q <= 2'h0;
            ovr_q <= 1'b0;
        end
        else
        begin
            buf_q[0] <= buf_d[0];
            buf_q[1] <= buf_d[1];
            cnt_q <= cnt_d;
            ovr_q <= ovr_d;
        end
    end

    // serialiser next state
    always_comb
    begin
        st_d = st_q;
        slot_d = slot_q;
        word_d = word_q;
        if (out_valid & out_ready)
        begin
            st_d = ST_SEND;
            slot_d = 3'h0;
            word_d = buf_q[0];
        end
        else if (st_q == ST_SEND)
        begin
            if (slot_q == 3'(pixel_link_pkg::SLOT_N - 1))
                st_d = ST_IDLE;
            else
                slot_d = slot_q + 3'h1;
        end
        if (!active)
        begin
            st_d = ST_IDLE;
            slot_d = 3'h0;
        end
    end

    // serialiser registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            st_q <= ST_IDLE;
            slot_q <= 3'h0;
            word_q <= pixel_link_pkg::WORD_RESET;
        end
        else
        begin
            st_q <= st_d;
            slot_q <= slot_d;
            word_q <= word_d;
        end
    end

    // lane bit selection, registered
    logic [2:0] lane_d, lane_q;
    logic fclk_d, fclk_q;
    always_comb
    begin
        for (int k = 0; k < int'(pixel_link_pkg::LANE_N); k++)
            lane_d[k] = word_q[k * int'(pixel_link_pkg::SLOT_N) + int'(slot_q)];
        fclk_d = pixel_link_pkg::FWD_CLK_PATTERN[slot_q];
        if (st_q != ST_SEND)
        begin
            lane_d = pixel_link_pkg::LANE_RESET;
            fclk_d = 1'b0;
        end
    end

    // output registers
    always_ff @(posedge core_clk or posedge rst)
    begin
        if (rst)
        begin
            lane_q <= pixel_link_pkg::LANE_RESET;
            fclk_q <= 1'b0;
        end
        else
        begin
            lane_q <= lane_d;
            fclk_q <= fclk_d;
        end
    end

    assign serial_lane_out = lane_q;
    assign forwarded_clock_out = fclk_q;
    assign serial_lane_oe = {3{active}};
    assign forwarded_clock_oe = active;
    assign overrun = ovr_q;

    property p_pd;
        @(posedge core_clk) disable iff (rst)
        !pd_s2_q |-> (serial_lane_oe == 3'h0) && !forwarded_clock_oe;
    endproperty
    a_pd: assert property (p_pd) else $error("driver on in power down");

    // lanes quiet once power down settles
    property p_pdq;
        @(posedge core_clk) disable iff (rst)
        (!pd_s2_q && !$past(pd_s2_q)) |=>
            (serial_lane_out == 3'h0) && !forwarded_clock_out;
    endproperty
    a_pdq: assert property (p_pdq) else $error("lanes busy");

    property p_fall;
        @(posedge core_clk) disable iff (rst)
        (fall && !sel_s2_q && pd_s2_q && cnt_q == 2'h0) |=> cnt_q != 2'h0;
    endproperty
    a_fall: assert property (p_fall) else $error("falling capture lost");

    // rising edge ignored when falling selected
    property p_sel;
        @(posedge core_clk) disable iff (rst)
        (rise && !sel_s2_q && !out_valid) |=> cnt_q == 2'h0;
    endproperty
    a_sel: assert property (p_sel) else $error("wrong strobe edge");

    property p_slots;
        @(posedge core_clk) disable iff (rst || !pd_s2_q)
        $rose(st_q == ST_SEND) |-> ##6 slot_q == 3'h6;
    endproperty
    a_slots: assert property (p_slots) else $error("slot count wrong");

    property p_fclk;
        @(posedge core_clk) disable iff (rst)
        (st_q == ST_SEND && slot_q == 3'h3 && pd_s2_q) |=> fclk_q;
    endproperty
    a_fclk: assert property (p_fclk) else $error("clock pattern wrong");

    // lane 2 carries bit 14 first
    property p_map;
        @(posedge core_clk) disable iff (rst)
        (st_q == ST_SEND && slot_q == 3'h0) |=>
            lane_q[2] == $past(word_q[14]);
    endproperty
    a_map: assert property (p_map) else $error("lane map wrong");

    property p_cap;
        @(posedge core_clk) disable iff (rst)
        (in_valid && cnt_q == 2'h0 && !out_ready) |=>
            buf_q[0] == $past(pix_s2_q);
    endproperty
    a_cap: assert property (p_cap) else $error("word capture wrong");

    property p_idle;
        @(posedge core_clk) disable iff (rst)
        st_q == ST_IDLE |=> (lane_q == 3'h0) && !fclk_q;
    endproperty
    a_idle: assert property (p_idle) else $error("lanes not idle");
endmodule

// *** verif/pixel_link_rx_model.sv ***
`timescale 1ns/1ps
// receiver side: frames seven slots on the forwarded clock
module pixel_link_rx_model (
    // serial side from the transmitter
    input wire logic core_clk,
    input wire logic [2:0] serial_lane_out,
    input wire logic forwarded_clock_out,
    input wire logic forwarded_clock_oe,
    // recovered word, strobe lasts one cycle
    output logic [20:0] rx_word = 21'h000000,
    output logic [6:0] rx_fclk = 7'h00,
    output logic rx_stb = 1'b0
);
    int slot = 7; // 7 means waiting for a frame
    logic [20:0] acc; // word under assembly
    logic [6:0] fc; // forwarded clock slots seen
    // deserialise one slot per core cycle
    always @(posedge core_clk)
    begin
        rx_stb <= 1'b0;
        // a disabled pair carries nothing, so never frame on it
        if (slot == 7 && forwarded_clock_oe && forwarded_clock_out)
            slot = 0;
        if (slot < 7)
        begin
            // lane k slot s is bit 7k+s
            for (int k = 0; k < 3; k++)
                acc[7*k+slot] = serial_lane_out[k];
            fc[slot] = forwarded_clock_out;
            slot++;
            if (slot == 7)
            begin
                rx_word <= acc;
                rx_fclk <= fc;
                rx_stb <= 1'b1;
            end
        end
    end
endmodule

// *** verif/pixel_lvds_serializer_tx_tb_top.sv ***
`timescale 1ns/1ps
module pixel_lvds_serializer_tx_tb_top;
    // pins of the block
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic shift_clock_in = 1'b0;
    logic [20:0] parallel_pixel_in = 21'h000000;
    logic strobe_edge_select = 1'b0;
    logic power_down_n = 1'b0;
    logic [2:0] lane, lane_oe;
    logic fclk, fclk_oe, overrun;
    // receiver view and bookkeeping
    logic [20:0] rx_word;
    logic [6:0] rx_fclk;
    logic rx_stb;
    logic [20:0] exp_q[$];
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;
    int n_word = 0;
    // expected forwarded clock slots, slot 0 in bit 0
    localparam logic [20:0] fclk_exp = 21'(pixel_link_pkg::FWD_CLK_PATTERN);

    // 125 MHz core clock
    always #4 core_clk = ~core_clk;

    pixel_lvds_serializer_tx dut (
        .core_clk(core_clk), .rst(rst), .shift_clock_in(shift_clock_in),
        .parallel_pixel_in(parallel_pixel_in),
        .strobe_edge_select(strobe_edge_select),
        .power_down_n(power_down_n), .serial_lane_out(lane),
        .serial_lane_oe(lane_oe), .forwarded_clock_out(fclk),
        .forwarded_clock_oe(fclk_oe), .overrun(overrun)
    );

    pixel_link_rx_model rx (
        .core_clk(core_clk), .serial_lane_out(lane),
        .forwarded_clock_out(fclk), .forwarded_clock_oe(fclk_oe),
        .rx_word(rx_word), .rx_fclk(rx_fclk), .rx_stb(rx_stb)
    );

    // compare seen against expected
    task automatic check(input logic [20:0] seen, input logic [20:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // next word: corner values first, then random
    function automatic logic [20:0] pick(input int n);
        logic [31:0] r;
        r = $urandom();
        case (n)
            0: return 21'h1FFFFF;
            1: return 21'h000000;
            2: return 21'h155555;
            default: return r[20:0];
        endcase
    endfunction

    // one half period of the 160 ns shift clock
    task automatic half();
        repeat (10) @(posedge core_clk);
        #1 shift_clock_in = ~shift_clock_in;
        if (shift_clock_in == strobe_edge_select)
        begin
            if (power_down_n)
                exp_q.push_back(parallel_pixel_in);
        end
        else
            parallel_pixel_in = pick(n_word++);
    endtask

    // watchdog and in-order word compare
    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_mismatch++;
            final_report();
        end
        if (rx_stb)
        begin
            check({14'h0000, rx_fclk}, fclk_exp);
            if (exp_q.size() == 0)
                check(21'(rx_stb), 21'h000000);
            else
                check(rx_word, exp_q.pop_front());
        end
    end

    // main sequence
    initial
    begin
        void'($urandom(92388));
        repeat (3) @(posedge core_clk);
        #1 rst = 1'b0;
        power_down_n = 1'b1;
        // falling edge by default, then rising edge
        for (int s = 0; s < 2; s++)
        begin
            strobe_edge_select = s[0];
            repeat (12) half();
            repeat (30) @(posedge core_clk);
            #1;
            check(21'(exp_q.size()), 21'h000000);
            check({17'h00000, lane_oe, fclk_oe}, 21'h00000F);
            $display("test edge %0d done", s);
        end
        power_down_n = 1'b0;
        repeat (4) half();
        check({17'h00000, lane_oe, fclk_oe}, 21'h000000);
        check({17'h00000, lane, fclk}, 21'h000000);
        power_down_n = 1'b1;
        repeat (4) half();
        repeat (30) @(posedge core_clk);
        check(21'(exp_q.size()), 21'h000000);
        check(21'(overrun), 21'h000000);
        $display("test power down done");
        final_report();
    end
endmodule
